// *** include/aos_pkg.sv ***
// register map, field layout and carrier types of the converter, amplifier
// and analog switch control bank.
// assumes an apb master on the system clock; the analog macros sit outside.
// ***************************************************************
// package
// ***************************************************************
package aos_pkg;

   localparam logic [7:0] AOS_OFS_DAC1_MODE = 8'h00;
   localparam logic [7:0] AOS_OFS_DAC1_LOW  = 8'h04;
   localparam logic [7:0] AOS_OFS_DAC1_HIGH = 8'h08;
   localparam logic [7:0] AOS_OFS_DAC2_MODE = 8'h0C;
   localparam logic [7:0] AOS_OFS_DAC2_LOW  = 8'h10;
   localparam logic [7:0] AOS_OFS_DAC2_HIGH = 8'h14;
   localparam logic [7:0] AOS_OFS_REF       = 8'h18;
   localparam logic [7:0] AOS_OFS_AMP1      = 8'h1C;
   localparam logic [7:0] AOS_OFS_AMP2      = 8'h20;
   localparam logic [7:0] AOS_OFS_AMP3      = 8'h24;
   localparam logic [7:0] AOS_OFS_PIN0      = 8'h28;
   localparam logic [7:0] AOS_PIN_STRIDE    = 8'h04;
   localparam logic [7:0] AOS_OFS_DAC_AMP   = 8'h50;

   localparam int         AOS_PINS          = 10;
   // implemented bits per pin switch register, pin 9 first
   localparam logic [9:0][7:0] AOS_PIN_MASK = {8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF,
                                               8'hFE, 8'hFE, 8'hFE, 8'hFE, 8'hFE};
   localparam logic [7:0] AOS_REF_MASK      = 8'h13;
   localparam logic [7:0] AOS_DAC_AMP_MASK  = 8'h8F;
   localparam int         AOS_REF_STAT_BIT  = 7;
   localparam int         AOS_AMP3_STAT_BIT = 5;
   localparam logic [1:0] AOS_MODE_FLOAT    = 2'h0;
   localparam logic [1:0] AOS_MODE_GROUND   = 2'h2;
   localparam logic [7:0] AOS_RST_BYTE      = 8'h00;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } aos_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } aos_apb_rsp_s;

   typedef struct packed {
      logic [1:0]  converter_mode_field;
      logic        enable;
      logic        ground;
      logic [11:0] converter_code_bits;
   } aos_dac_s;

   typedef struct packed {
      logic       calibration_mode;
      logic       calibration_reference;
      logic       enable;
      logic [4:0] offset_trim;
   } aos_amp_s;

   typedef struct packed {
      logic       enable;
      logic       fwr_mode;
      logic [3:0] gain;
   } aos_amp3_s;

   typedef struct packed {
      logic       enable;
      logic [1:0] dac_ref_sel;
   } aos_ref_s;

endpackage : aos_pkg

// *** rtl/aos_regs.sv ***
// converter, amplifier and analog switch control registers behind apb.
// assumes apb inputs synchronous to clk and amplifier comparator levels
// already synchronous; analog switching itself happens outside.
`timescale 1ns/10ps
module aos_regs
   import aos_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ADDR_W-1:0]      paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [1:0]             amp_cmp_in,
   output      logic [31:0]            prdata,
   output      logic                   pready,
   output      logic                   pslverr,
   output      aos_dac_s [1:0]         dac_out,
   output      aos_amp_s [1:0]         amp_out,
   output      aos_amp3_s              amp3_out,
   output      aos_ref_s               ref_out,
   output      logic [AOS_PINS-1:0][7:0] pin_switch_register,
   output      logic [7:0]             converter_amp_switch_register,
   output      logic [1:0]             amp_compare_status
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      aos_apb_rsp_s             rsp;
      aos_dac_s [1:0]           dac;
      logic [1:0][3:0]          low_stage;
      aos_amp_s [1:0]           amp;
      aos_amp3_s                amp3;
      aos_ref_s                 refc;
      logic [AOS_PINS-1:0][7:0] pin;
      logic [7:0]               dac_amp;
      logic [1:0]               stat;
   } aos_state_s;

   aos_state_s   s_r;
   aos_state_s   s_nxt;
   aos_apb_req_s req;
   logic [AOS_PINS-1:0] pin_sel;
   logic         upper_ok;

   generate
      if (ADDR_W < 8) begin : g_bad_width
         $error("aos_regs needs ADDR_W of at least 8");
      end
      if (ADDR_W > 8) begin : g_upper
         assign upper_ok = (paddr[ADDR_W-1:8] == '0);
      end else begin : g_no_upper
         assign upper_ok = 1'b1;
      end
   endgenerate

   assign req.psel    = psel;
   assign req.penable = penable;
   assign req.pwrite  = pwrite;
   assign req.paddr   = paddr[7:0];
   assign req.pwdata  = pwdata;

   // ***************************************************************
   // pin switch decode
   // ***************************************************************
   genvar p;
   generate
      for (p = 0; p < AOS_PINS; p++) begin : g_pin
         assign pin_sel[p] = upper_ok &&
            (req.paddr == AOS_OFS_PIN0 + AOS_PIN_STRIDE * 8'(p));
      end
   endgenerate

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic       hit;
      logic [7:0] rd;
      logic       wr;
      logic [7:0] wd;
      logic [7:0] a;
      s_nxt = s_r;
      a     = req.paddr;
      wd    = req.pwdata[7:0];
      hit   = 1'b0;
      rd    = 8'h00;
      wr    = 1'b0;
      // mode regs expose only two bits, rest reads zero
      if (upper_ok) begin
         unique case (a)
            AOS_OFS_DAC1_MODE: begin
               hit = 1'b1;
               rd  = {6'h00, s_r.dac[0].converter_mode_field};
            end
            AOS_OFS_DAC2_MODE: begin
               hit = 1'b1;
               rd  = {6'h00, s_r.dac[1].converter_mode_field};
            end
            AOS_OFS_DAC1_LOW: begin
               hit = 1'b1;
               rd  = {s_r.low_stage[0], 4'h0};
            end
            AOS_OFS_DAC2_LOW: begin
               hit = 1'b1;
               rd  = {s_r.low_stage[1], 4'h0};
            end
            AOS_OFS_DAC1_HIGH: begin
               hit = 1'b1;
               rd  = s_r.dac[0].converter_code_bits[11:4];
            end
            AOS_OFS_DAC2_HIGH: begin
               hit = 1'b1;
               rd  = s_r.dac[1].converter_code_bits[11:4];
            end
            AOS_OFS_REF: begin
               hit = 1'b1;
               rd  = {s_r.stat[0], 2'h0, s_r.refc.enable, 2'h0,
                      s_r.refc.dac_ref_sel};
            end
            AOS_OFS_AMP1: begin
               hit = 1'b1;
               rd  = s_r.amp[0];
            end
            AOS_OFS_AMP2: begin
               hit = 1'b1;
               rd  = s_r.amp[1];
            end
            AOS_OFS_AMP3: begin
               hit = 1'b1;
               rd  = {s_r.amp3.enable, s_r.amp3.fwr_mode, s_r.stat[1], 1'b0,
                      s_r.amp3.gain};
            end
            AOS_OFS_DAC_AMP: begin
               hit = 1'b1;
               rd  = s_r.dac_amp;
            end
            default: begin
               hit = 1'b0;
               rd  = 8'h00;
            end
         endcase
      end
      for (int i = 0; i < AOS_PINS; i++) begin
         if (pin_sel[i]) begin
            hit = 1'b1;
            rd  = s_r.pin[i];
         end
      end

      // setup phase latches the answer; the access phase then ends at once
      s_nxt.rsp.pready = 1'b0;
      if (req.psel && !req.penable) begin
         s_nxt.rsp.pready  = 1'b1;
         s_nxt.rsp.prdata  = {24'h000000, rd};
         s_nxt.rsp.pslverr = ~hit;
      end
      // a write lands only on the access edge that completes it
      wr = req.psel && req.penable && s_r.rsp.pready && req.pwrite && hit;

      if (wr) begin
         unique case (a)
            AOS_OFS_DAC1_MODE: s_nxt.dac[0].converter_mode_field = wd[1:0];
            AOS_OFS_DAC2_MODE: s_nxt.dac[1].converter_mode_field = wd[1:0];
            AOS_OFS_DAC1_LOW:  s_nxt.low_stage[0] = wd[7:4];
            AOS_OFS_DAC2_LOW:  s_nxt.low_stage[1] = wd[7:4];
            // whole code moves together so the analog side never sees a mix
            AOS_OFS_DAC1_HIGH: s_nxt.dac[0].converter_code_bits =
                                  {wd, s_r.low_stage[0]};
            AOS_OFS_DAC2_HIGH: s_nxt.dac[1].converter_code_bits =
                                  {wd, s_r.low_stage[1]};
            AOS_OFS_REF: begin
               s_nxt.refc.enable      = wd[4];
               s_nxt.refc.dac_ref_sel = wd[1:0];
            end
            AOS_OFS_AMP1: s_nxt.amp[0] = wd;
            AOS_OFS_AMP2: s_nxt.amp[1] = wd;
            AOS_OFS_AMP3: begin
               s_nxt.amp3.enable   = wd[7];
               s_nxt.amp3.fwr_mode = wd[6];
               s_nxt.amp3.gain     = wd[3:0];
            end
            AOS_OFS_DAC_AMP: s_nxt.dac_amp = wd & AOS_DAC_AMP_MASK;
            default: begin
            end
         endcase
         // shorts between switches are not blocked, software owns that
         for (int i = 0; i < AOS_PINS; i++) begin
            if (pin_sel[i]) begin
               s_nxt.pin[i] = wd & AOS_PIN_MASK[i];
            end
         end
      end

      // decoded converter state follows the stored mode
      for (int c = 0; c < 2; c++) begin
         s_nxt.dac[c].enable = s_nxt.dac[c].converter_mode_field[0];
         s_nxt.dac[c].ground =
            (s_nxt.dac[c].converter_mode_field == AOS_MODE_GROUND);
         // status uses the next enable so a disable clears it on the same edge
         s_nxt.stat[c] = s_nxt.amp[c].enable & amp_cmp_in[c];
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign prdata                        = s_r.rsp.prdata;
   assign pready                        = s_r.rsp.pready;
   assign pslverr                       = s_r.rsp.pslverr;
   assign dac_out                       = s_r.dac;
   assign amp_out                       = s_r.amp;
   assign amp3_out                      = s_r.amp3;
   assign ref_out                       = s_r.refc;
   assign pin_switch_register           = s_r.pin;
   assign converter_amp_switch_register = s_r.dac_amp;
   assign amp_compare_status            = s_r.stat;

endmodule : aos_regs

// *** testbench/aos_regs_props.sv ***
// concurrent checks on the ports of the converter, amplifier and switch bank.
// assumes one clock domain and the default address width of the bank.
`timescale 1ns/10ps
// ***************************************************************
// checker
// ***************************************************************
module aos_regs_props
   import aos_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input wire logic                     clk,
   input wire logic                     sys_rst,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [ADDR_W-1:0]        paddr,
   input wire logic [31:0]              pwdata,
   input wire logic [1:0]               amp_cmp_in,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire aos_dac_s [1:0]           dac_out,
   input wire aos_amp_s [1:0]           amp_out,
   input wire aos_amp3_s                amp3_out,
   input wire aos_ref_s                 ref_out,
   input wire logic [AOS_PINS-1:0][7:0] pin_switch_register,
   input wire logic [7:0]               converter_amp_switch_register,
   input wire logic [1:0]               amp_compare_status
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_ready_after_setup: assert property (psel && !penable |=> pready && $past(psel))
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_unmapped_error: assert property (psel && !penable && paddr > AOS_OFS_DAC_AMP
      |=> pready && pslverr) else $error("unmapped access not refused");
   a_mode_read_zero: assert property (pready && !pwrite && paddr == AOS_OFS_DAC1_MODE
      |-> prdata[7:2] == 6'h00) else $error("mode register upper bits not zero");
   a_mode_decode: assert property (dac_out[0].enable == dac_out[0].converter_mode_field[0]
      && dac_out[0].ground == (dac_out[0].converter_mode_field == AOS_MODE_GROUND))
      else $error("converter mode decode wrong");
   // the code must never move on a low write alone, else a half-updated value reaches the pin
   a_code_on_high: assert property ($changed(dac_out[0].converter_code_bits)
      |-> $past(psel && penable && pwrite && paddr == AOS_OFS_DAC1_HIGH) || $past(sys_rst))
      else $error("converter code moved without high write");
   a_pin_unimpl: assert property (pin_switch_register[0][0] == 1'b0
      && pin_switch_register[8][7:6] == 2'h0 && pin_switch_register[9][7:6] == 2'h0)
      else $error("unimplemented pin switch bit set");
   a_link_gap: assert property (converter_amp_switch_register[6:4] == 3'h0)
      else $error("converter amp switch gap bits set");
   a_status_off: assert property (!amp_out[0].enable && $past(!amp_out[0].enable)
      |-> !amp_compare_status[0]) else $error("status set while amp disabled");
   a_status_track: assert property (amp_out[1].enable && $past(amp_out[1].enable)
      |-> amp_compare_status[1] == $past(amp_cmp_in[1])) else $error("status not tracking");
endmodule : aos_regs_props

bind aos_regs aos_regs_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .amp_cmp_in(amp_cmp_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .dac_out(dac_out), .amp_out(amp_out), .amp3_out(amp3_out), .ref_out(ref_out),
   .pin_switch_register(pin_switch_register),
   .converter_amp_switch_register(converter_amp_switch_register),
   .amp_compare_status(amp_compare_status));

// *** testbench/tb_top.sv ***
// directed bench for the control bank: apb tasks and register sequences.
// assumes the bank with its default address width; comparator levels driven here.
`timescale 1ns/10ps
module tb_top;
   import aos_pkg::*;
   // ***************************************************************
   // stimulus and checks
   // ***************************************************************
   logic                     clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]               paddr;
   logic [31:0]              pwdata, prdata, q;
   logic [1:0]               cmp, stat;
   aos_dac_s [1:0]           dac;
   aos_amp_s [1:0]           amp;
   aos_amp3_s                amp3;
   aos_ref_s                 refo;
   logic [AOS_PINS-1:0][7:0] pins;
   logic [7:0]               link;
   int                       fails = 0;
   int                       tests_run = 0;

   aos_regs DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .amp_cmp_in(cmp), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dac_out(dac), .amp_out(amp), .amp3_out(amp3),
      .ref_out(refo), .pin_switch_register(pins), .converter_amp_switch_register(link),
      .amp_compare_status(stat));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   // idle edge first, so no strobe is assigned twice in one time step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         AOS_OFS_DAC1_MODE, AOS_OFS_DAC2_MODE: return 8'h03;
         AOS_OFS_DAC1_LOW, AOS_OFS_DAC2_LOW:   return 8'hF0;
         AOS_OFS_REF:                          return 8'h13;
         AOS_OFS_AMP3:                         return 8'hCF;
         AOS_OFS_DAC_AMP:                      return 8'h8F;
         default: return (a < 8'h28) ? 8'hFF : (a < 8'h3C) ? 8'hFE : (a < 8'h48) ? 8'hFF : 8'h3F;
      endcase
   endfunction : wmask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (4000) @(posedge clk);
      fails++;
      give_verdict();
   end

   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata, cmp} = {4'h8, 8'h00, 32'h0, 2'h0};
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a <= 8'h50; a += 4) begin
         xfer(1'b0, 8'(a), 32'h0);
         chk(q, 32'h0);
      end
      $display("test reset values done");
      // low before high; each AMP1 and AMP2 write sets the reference and calibration bits together
      for (int a = 0; a <= 8'h24; a += 4) xfer(1'b1, 8'(a), 32'hFFFF_FFFF);
      for (int a = 0; a <= 8'h24; a += 4) begin
         xfer(1'b0, 8'(a), 32'h0);
         chk(q, {24'h0, wmask(8'(a))});
      end
      // one switch bit per write, but each register keeps its last bit, so pins 0 to 7 and the amp switch register end with bit 7 set together
      for (int a = 8'h28; a <= 8'h50; a += 4) begin
         for (int b = 0; b < 8; b++) begin
            xfer(1'b1, 8'(a), 32'(1 << b));
            xfer(1'b0, 8'(a), 32'h0);
            chk(q, 32'(wmask(8'(a)) & 8'(1 << b)));
         end
      end
      @(negedge clk);
      chk(32'({dac[0].converter_code_bits, amp[0], link}), 32'hFFF_FF80);
      chk(32'({pins[9], pins[8], pins[5], pins[0]}), 32'h0000_8080);
      chk(32'({refo, amp3}), 32'h1FF);
      $display("test write masks done");
      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, AOS_OFS_DAC2_MODE, 32'(m));
         @(negedge clk);
         chk(32'({dac[1].enable, dac[1].ground}), m[0] ? 32'h2 : (m == 2) ? 32'h1 : 32'h0);
      end
      $display("test converter modes done");
      xfer(1'b1, AOS_OFS_DAC1_LOW, 32'hA5);
      @(negedge clk);
      chk(32'(dac[0].converter_code_bits), 32'hFFF);
      xfer(1'b0, AOS_OFS_DAC1_LOW, 32'h0);
      chk(q, 32'hA0);
      xfer(1'b1, AOS_OFS_DAC1_HIGH, 32'h5C);
      @(negedge clk);
      chk(32'(dac[0].converter_code_bits), 32'h5CA);
      xfer(1'b1, AOS_OFS_DAC1_HIGH, 32'h12);
      @(negedge clk);
      chk(32'(dac[0].converter_code_bits), 32'h12A);
      $display("test code staging done");
      cmp <= 2'b11;
      xfer(1'b0, AOS_OFS_REF, 32'h0);
      chk(q, 32'h93);
      xfer(1'b0, AOS_OFS_AMP3, 32'h0);
      chk(q, 32'hEF);
      xfer(1'b1, AOS_OFS_AMP1, 32'hDF);
      cmp <= 2'b01;
      xfer(1'b0, AOS_OFS_REF, 32'h0);
      chk(q, 32'h13);
      xfer(1'b0, AOS_OFS_AMP3, 32'h0);
      chk(q, 32'hCF);
      chk(32'(amp[0]), 32'hDF);
      $display("test amp status done");
      xfer(1'b1, 8'h54, 32'hFF);
      chk(32'(e), 32'h1);
      xfer(1'b0, 8'h54, 32'h0);
      chk({q[31:1], e}, 32'h1);
      xfer(1'b0, 8'h02, 32'h0);
      chk(32'(e), 32'h1);
      $display("test refused access done");
      give_verdict();
   end
endmodule : tb_top
